// *** rtl/pipe_lane_control.sv ***
// Sideband control input handling for one PHY lane, with APB status and control
// Function
// - Detect request starts receiver detection
// - After power-up, request starts loopback
// - One-cycle compliance pulse forces negative disparity
// - Polarity input inverts received data
// - Move to requested two-bit power state
// - Margin codes 010 and 011 reserved
// - Swing selects full or half levels
// - Gen2 de-emphasis: 0 is -6, 1 is -3.5
// - Gen3 word splits into three coefficients
// - Gen3-capable: Gen2 -6 dB, Gen1 -3.5 dB
// - Apply asynchronous receive preset hint
// - Top bit set selects idle inference
// - Code 100: no COM/SKP in 128 ms
// - Code 101: no TS1/TS2 in 1280 UI
// - Code 110: no exit in 2000/16000 UI
// - Code 111: no exit in 128 ms, Gen1
// - Rate codes Gen1, Gen2, Gen3
`timescale 1ns/1ps
`include "pipe_lane_regs.svh"
module pipe_lane_control #(
  parameter int LONG_WINDOW = `LONG_WINDOW_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic detect_loopback,
  input wire logic compliance,
  input wire logic rx_polarity,
  input wire logic [1:0] powerdown,
  input wire logic [2:0] tx_margin,
  input wire logic tx_swing,
  input wire logic tx_deemph,
  input wire logic [17:0] gen3_tx_coefficients,
  input wire logic [2:0] rx_preset_hint,
  input wire logic [2:0] eidle_infer_sel,
  input wire logic [1:0] rate,
  input wire logic powerup_done,
  input wire logic com_skp_seen,
  input wire logic ts_seen,
  input wire logic eidle_exit,
  output logic start_detect,
  output logic start_loopback,
  output logic detect_active,
  output logic loopback_active,
  output logic force_neg_disparity,
  output logic rx_invert,
  output logic [1:0] power_state,
  output logic [2:0] margin,
  output logic half_swing,
  output logic deemph_3p5db,
  output logic [5:0] coef_pre,
  output logic [5:0] coef_main,
  output logic [5:0] coef_post,
  output logic [2:0] rx_preset,
  output logic eidle_inferred
);
  localparam logic [22:0] TS_G1 = 23'(`TS_G1_CYCLES);
  localparam logic [22:0] TS_G2 = 23'(`TS_G2_CYCLES);
  localparam logic [22:0] EXIT_G1 = 23'(`EXIT_G1_CYCLES);
  localparam logic [22:0] EXIT_G2 = 23'(`EXIT_G2_CYCLES);
  localparam logic [22:0] LONG_CNT = 23'(LONG_WINDOW);

  pipe_lane_pkg::lane_s s;
  pipe_lane_pkg::lane_s next_s;
  logic rx_polarity_s;
  logic tx_deemph_s;
  logic [17:0] coef_s;
  logic [2:0] preset_s;
  logic [2:0] infer_sel_s;
  logic [1:0] rate_s;
  pipe_lane_pkg::rate_e rate_q;
  pipe_lane_pkg::infer_e sel_q;
  logic [22:0] limit;
  logic event_seen;
  logic wr;
  logic setup;

  // Asynchronous inputs cross into the lane clock as one group
  sync_stage #(
    .WIDTH(28)
  ) async_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({rx_polarity, tx_deemph, gen3_tx_coefficients, rx_preset_hint, eidle_infer_sel,
      rate}),
    .sync_out({rx_polarity_s, tx_deemph_s, coef_s, preset_s, infer_sel_s, rate_s})
  );

  assign rate_q = pipe_lane_pkg::rate_e'(rate_s);
  assign sel_q = pipe_lane_pkg::infer_e'(infer_sel_s);
  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;

  // Inference window and the event that restarts it
  always_comb
  begin
    limit = '0;
    event_seen = 1'b0;
    unique case (sel_q)
      pipe_lane_pkg::INF_COM_SKP:
      begin
        limit = LONG_CNT;
        event_seen = com_skp_seen;
      end
      pipe_lane_pkg::INF_TS:
      begin
        limit = (rate_q == pipe_lane_pkg::GEN1) ? TS_G1 :
          (rate_q == pipe_lane_pkg::GEN2) ? TS_G2 : '0;
        event_seen = ts_seen;
      end
      pipe_lane_pkg::INF_EXIT_UI:
      begin
        limit = (rate_q == pipe_lane_pkg::GEN1) ? EXIT_G1 :
          (rate_q == pipe_lane_pkg::GEN2) ? EXIT_G2 : '0;
        event_seen = eidle_exit;
      end
      pipe_lane_pkg::INF_EXIT_LONG:
      begin
        limit = (rate_q == pipe_lane_pkg::GEN1) ? LONG_CNT : '0;
        event_seen = eidle_exit;
      end
      default:
      begin
        limit = '0;
        event_seen = 1'b0;
      end
    endcase
  end

  // Next state of the lane controls and the register file
  always_comb
  begin
    next_s = s;
    // Detect request: detection before power-up, loopback after
    next_s.req_q = detect_loopback;
    next_s.start_detect = detect_loopback && !s.req_q && !powerup_done;
    next_s.start_loopback = detect_loopback && !s.req_q && powerup_done;
    next_s.detect_active = detect_loopback && !powerup_done;
    next_s.loopback_active = detect_loopback && powerup_done;
    next_s.force_neg_disp = compliance;
    next_s.rx_invert = rx_polarity_s;
    next_s.power_state = pipe_lane_pkg::power_e'(powerdown);
    // Reserved margin codes keep the last legal range and flag it
    if (tx_margin == 3'h2 || tx_margin == 3'h3)
      next_s.margin_err = 1'b1;
    else
      next_s.margin = tx_margin;
    next_s.swing = tx_swing;
    // De-emphasis by rate
    unique case (rate_q)
      pipe_lane_pkg::GEN1:
        next_s.deemph_3p5db = s.gen3_cap ? 1'b1 : tx_deemph_s;
      pipe_lane_pkg::GEN2:
        next_s.deemph_3p5db = s.gen3_cap ? 1'b0 : tx_deemph_s;
      pipe_lane_pkg::GEN3:
      begin
        next_s.coef_pre = coef_s[5:0];
        next_s.coef_main = coef_s[11:6];
        next_s.coef_post = coef_s[17:12];
      end
      default:
        next_s.deemph_3p5db = s.deemph_3p5db;
    endcase
    next_s.preset = preset_s;
    // Electrical idle inference counter
    next_s.infer_sel = sel_q;
    if (!s.infer_en || !sel_q[2] || limit == '0 || sel_q != s.infer_sel || event_seen)
    begin
      next_s.infer_cnt = '0;
      next_s.eidle_inferred = 1'b0;
    end
    else if (s.infer_cnt >= limit - 23'h1)
      next_s.eidle_inferred = 1'b1;
    else
      next_s.infer_cnt = s.infer_cnt + 23'h1;
    // APB writes
    if (wr && paddr == `CTRL_OFFSET)
    begin
      next_s.infer_en = pwdata[`CTRL_INFER_EN_BIT];
      next_s.gen3_cap = pwdata[`CTRL_GEN3_CAP_BIT];
    end
    if (wr && paddr == `STATUS_OFFSET && pwdata[`ST_MARGIN_ERR_BIT]
        && !(tx_margin == 3'h2 || tx_margin == 3'h3))
      next_s.margin_err = 1'b0;
    // APB read data is staged in the setup phase
    if (setup)
    begin
      next_s.prdata = '0;
      next_s.pslverr = 1'b0;
      unique case (paddr)
        `CTRL_OFFSET:
        begin
          next_s.prdata[`CTRL_INFER_EN_BIT] = s.infer_en;
          next_s.prdata[`CTRL_GEN3_CAP_BIT] = s.gen3_cap;
        end
        `STATUS_OFFSET:
        begin
          next_s.prdata[`ST_POWER_LSB +: 2] = s.power_state;
          next_s.prdata[`ST_RATE_LSB +: 2] = rate_s;
          next_s.prdata[`ST_DETECT_BIT] = s.detect_active;
          next_s.prdata[`ST_LOOPBACK_BIT] = s.loopback_active;
          next_s.prdata[`ST_INVERT_BIT] = s.rx_invert;
          next_s.prdata[`ST_EIDLE_BIT] = s.eidle_inferred;
          next_s.prdata[`ST_MARGIN_ERR_BIT] = s.margin_err;
        end
        `TXLEVEL_OFFSET:
        begin
          next_s.prdata[`TL_MARGIN_LSB +: 3] = s.margin;
          next_s.prdata[`TL_SWING_BIT] = s.swing;
          next_s.prdata[`TL_DEEMPH_BIT] = s.deemph_3p5db;
          next_s.prdata[`TL_PRESET_LSB +: 3] = s.preset;
        end
        `COEF_OFFSET:
        begin
          next_s.prdata[`COEF_PRE_LSB +: 6] = s.coef_pre;
          next_s.prdata[`COEF_MAIN_LSB +: 6] = s.coef_main;
          next_s.prdata[`COEF_POST_LSB +: 6] = s.coef_post;
        end
        default:
          next_s.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.power_state <= pipe_lane_pkg::power_e'(`POWER_RESET);
      s.infer_en <= 1'(`CTRL_RESET >> `CTRL_INFER_EN_BIT);
      s.gen3_cap <= 1'(`CTRL_RESET >> `CTRL_GEN3_CAP_BIT);
    end
    else
      s <= next_s;
  end

  // Outputs straight from the state register; pready is tied high
  assign pready = 1'b1;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign start_detect = s.start_detect;
  assign start_loopback = s.start_loopback;
  assign detect_active = s.detect_active;
  assign loopback_active = s.loopback_active;
  assign force_neg_disparity = s.force_neg_disp;
  assign rx_invert = s.rx_invert;
  assign power_state = s.power_state;
  assign margin = s.margin;
  assign half_swing = s.swing;
  assign deemph_3p5db = s.deemph_3p5db;
  assign coef_pre = s.coef_pre;
  assign coef_main = s.coef_main;
  assign coef_post = s.coef_post;
  assign rx_preset = s.preset;
  assign eidle_inferred = s.eidle_inferred;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Detection versus loopback choice
  detect_before_power_a: assert property (
    $rose(detect_loopback) && !powerup_done |=> start_detect && !start_loopback)
    else $error("detect request did not start detection");
  detect_pulse_a: assert property (start_detect |=> !start_detect)
    else $error("detection start lasted more than one cycle");
  loopback_after_power_a: assert property (
    detect_loopback && powerup_done |=> loopback_active && !detect_active)
    else $error("detect request after power-up did not start loopback");
  loopback_pulse_a: assert property (start_loopback |=> !start_loopback)
    else $error("loopback start lasted more than one cycle");
  // Compliance pulse lasts exactly one cycle
  compliance_pulse_a: assert property (
    $rose(compliance) ##1 !compliance |-> force_neg_disparity ##1 !force_neg_disparity)
    else $error("disparity force did not follow compliance pulse");
  // Asynchronous inputs reach their outputs after the synchroniser and one register
  polarity_follow_a: assert property (
    $stable(rx_polarity) [*4] |-> rx_invert == rx_polarity)
    else $error("receive inversion does not follow polarity input");
  preset_follow_a: assert property (
    $stable(rx_preset_hint) [*4] |-> rx_preset == rx_preset_hint)
    else $error("receive preset does not follow the hint");
  // Synchronous levels follow one cycle later; the guard skips the release edge
  power_follow_a: assert property (presetn |=> power_state == $past(powerdown))
    else $error("power state does not follow request");
  swing_follow_a: assert property (presetn |=> half_swing == $past(tx_swing))
    else $error("swing does not follow input");
  // Reserved margin codes never reach the transmitter
  margin_legal_a: assert property (margin != 3'h2 && margin != 3'h3)
    else $error("reserved margin code reached the transmitter");
  margin_hold_a: assert property (
    tx_margin == 3'h2 || tx_margin == 3'h3 |=> $stable(margin) && s.margin_err)
    else $error("reserved margin code changed the range");
  // De-emphasis by rate and capability
  gen2_deemph_a: assert property (
    !s.gen3_cap && rate_q == pipe_lane_pkg::GEN2 |=> deemph_3p5db == $past(tx_deemph_s))
    else $error("gen2 de-emphasis does not follow its input");
  gen3_cap_deemph_a: assert property (
    s.gen3_cap && rate_q == pipe_lane_pkg::GEN2 |=> !deemph_3p5db)
    else $error("gen2 de-emphasis not -6 dB in gen3-capable mode");
  gen1_cap_deemph_a: assert property (
    s.gen3_cap && rate_q == pipe_lane_pkg::GEN1 |=> deemph_3p5db)
    else $error("gen1 de-emphasis not -3.5 dB in gen3-capable mode");
  coef_split_a: assert property (
    rate_q == pipe_lane_pkg::GEN3 |=> coef_pre == $past(coef_s[5:0])
      && coef_main == $past(coef_s[11:6]) && coef_post == $past(coef_s[17:12]))
    else $error("gen3 coefficients split wrongly");
  // Electrical idle inference
  no_infer_low_a: assert property (!infer_sel_s[2] |=> !eidle_inferred)
    else $error("idle inferred with inference off");
  infer_fires_a: assert property (
    s.infer_en && sel_q[2] && limit != '0 && sel_q == s.infer_sel && !event_seen
      && s.infer_cnt == limit - 23'h1 |=> eidle_inferred)
    else $error("idle not inferred when the window ran out");
  ts_window_a: assert property (
    s.infer_en && sel_q == pipe_lane_pkg::INF_TS && rate_q == pipe_lane_pkg::GEN1
      && !ts_seen && !eidle_inferred && s.infer_cnt == '0 && s.infer_sel == sel_q
      ##1 (sel_q == pipe_lane_pkg::INF_TS && !ts_seen && $stable(rate_q)) [*8]
      |-> !eidle_inferred)
    else $error("idle inferred before the TS window ended");
  exit_clears_a: assert property (
    eidle_exit && (sel_q == pipe_lane_pkg::INF_EXIT_UI) |=> !eidle_inferred)
    else $error("idle inference not cleared by exit");

  // Main scenarios
  detect_cov: cover property ($rose(start_detect));
  loopback_cov: cover property ($rose(start_loopback));
  infer_cov: cover property ($rose(eidle_inferred));
  margin_err_cov: cover property ($rose(s.margin_err));
  compliance_cov: cover property ($rose(force_neg_disparity));
endmodule : pipe_lane_control

// *** rtl/pipe_lane_regs.svh ***
// Register offsets, field positions, reset values and timing counts for the lane control block
`ifndef PIPE_LANE_REGS_SVH
`define PIPE_LANE_REGS_SVH
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define TXLEVEL_OFFSET 12'h008
`define COEF_OFFSET 12'h00C
`define CTRL_INFER_EN_BIT 0
`define CTRL_GEN3_CAP_BIT 1
`define CTRL_RESET 2'h1
`define ST_POWER_LSB 0
`define ST_RATE_LSB 2
`define ST_DETECT_BIT 4
`define ST_LOOPBACK_BIT 5
`define ST_INVERT_BIT 6
`define ST_EIDLE_BIT 7
`define ST_MARGIN_ERR_BIT 8
`define TL_MARGIN_LSB 0
`define TL_SWING_BIT 3
`define TL_DEEMPH_BIT 4
`define TL_PRESET_LSB 8
`define COEF_PRE_LSB 0
`define COEF_MAIN_LSB 6
`define COEF_POST_LSB 12
`define POWER_RESET 2'h2
`define CLK_PERIOD_PS 25000
`define CLK_PERIOD_NS 25
`define UI_GEN1_PS 400
`define UI_GEN2_PS 200
`define TS_WINDOW_UI 1280
`define EXIT_WINDOW_G1_UI 2000
`define EXIT_WINDOW_G2_UI 16000
`define LONG_WINDOW_NS 128000000
`define TS_G1_CYCLES ((`TS_WINDOW_UI * `UI_GEN1_PS) / `CLK_PERIOD_PS)
`define TS_G2_CYCLES ((`TS_WINDOW_UI * `UI_GEN2_PS) / `CLK_PERIOD_PS)
`define EXIT_G1_CYCLES ((`EXIT_WINDOW_G1_UI * `UI_GEN1_PS) / `CLK_PERIOD_PS)
`define EXIT_G2_CYCLES ((`EXIT_WINDOW_G2_UI * `UI_GEN2_PS) / `CLK_PERIOD_PS)
`define LONG_WINDOW_CYCLES (`LONG_WINDOW_NS / `CLK_PERIOD_NS)
`endif

// *** rtl/pipe_lane_pkg.sv ***
// Types shared by the lane control block
package pipe_lane_pkg;
  typedef enum logic [1:0] {GEN1 = 2'h0, GEN2 = 2'h1, GEN3 = 2'h2, RATE_RSVD = 2'h3} rate_e;
  typedef enum logic [1:0] {P0 = 2'h0, P0S = 2'h1, P1 = 2'h2, P2 = 2'h3} power_e;
  typedef enum logic [2:0] {
    INF_NONE0 = 3'h0, INF_NONE1 = 3'h1, INF_NONE2 = 3'h2, INF_NONE3 = 3'h3,
    INF_COM_SKP = 3'h4, INF_TS = 3'h5, INF_EXIT_UI = 3'h6, INF_EXIT_LONG = 3'h7
  } infer_e;
  typedef struct packed {
    logic req_q;
    logic start_detect;
    logic start_loopback;
    logic detect_active;
    logic loopback_active;
    logic force_neg_disp;
    logic rx_invert;
    power_e power_state;
    logic [2:0] margin;
    logic margin_err;
    logic swing;
    logic deemph_3p5db;
    logic [5:0] coef_pre;
    logic [5:0] coef_main;
    logic [5:0] coef_post;
    logic [2:0] preset;
    infer_e infer_sel;
    logic [22:0] infer_cnt;
    logic eidle_inferred;
    logic infer_en;
    logic gen3_cap;
    logic [31:0] prdata;
    logic pslverr;
  } lane_s;
endpackage : pipe_lane_pkg

// *** rtl/sync_stage.sv ***
// Two-flop synchroniser for asynchronous lane inputs
`timescale 1ns/1ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;
  sync_s s;
  sync_s next_s;

  // First flop feeds only the second
  always_comb
  begin
    next_s.meta = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign sync_out = s.stable;
endmodule : sync_stage

// *** test/pipe_mac_model.sv ***
// Model of the link-layer controller that drives one lane's sideband inputs
`timescale 1ns/1ps
module pipe_mac_model (
  input wire logic pclk,
  output logic detect_loopback,
  output logic compliance,
  output logic rx_polarity,
  output logic [1:0] powerdown,
  output logic [2:0] tx_margin,
  output logic tx_swing,
  output logic tx_deemph,
  output logic [17:0] gen3_tx_coefficients,
  output logic [2:0] rx_preset_hint,
  output logic [2:0] eidle_infer_sel,
  output logic [1:0] rate
);
  // Quiet lane inputs at time zero
  initial
  begin
    {detect_loopback, compliance, rx_polarity, tx_swing, tx_deemph} = 5'h00;
    {powerdown, tx_margin, rx_preset_hint, eidle_infer_sel, rate} = 13'h0000;
    gen3_tx_coefficients = 18'h00000;
  end
  // Compliance request lasts exactly one clock
  task pulse_comp();
    @(posedge pclk) compliance <= 1'b1;
    @(posedge pclk) compliance <= 1'b0;
  endtask : pulse_comp
  task set_detect(input logic v);
    @(posedge pclk) detect_loopback <= v;
  endtask : set_detect
  task set_power(input logic [1:0] p);
    @(posedge pclk) powerdown <= p;
  endtask : set_power
  // Margin follows the link setting; reserved codes only when told to
  task set_tx(input logic [2:0] m, input logic sw, input logic rsvd_ok);
    @(posedge pclk);
    if (rsvd_ok || m[2:1] != 2'b01)
      tx_margin <= m;
    tx_swing <= sw;
  endtask : set_tx
  task set_async(input logic pol, input logic dm, input logic [17:0] c, input logic [2:0] h);
    @(posedge pclk);
    rx_polarity <= pol;
    tx_deemph <= dm;
    gen3_tx_coefficients <= c;
    rx_preset_hint <= h;
  endtask : set_async
  // Only defined rate codes are sent
  task set_mode(input logic [1:0] r, input logic [2:0] s);
    @(posedge pclk);
    if (r != 2'h3)
      rate <= r;
    eidle_infer_sel <= s;
  endtask : set_mode
endmodule : pipe_mac_model

// *** test/pipe_lane_control_inputs_tb.sv ***
// Self-checking bench for the lane sideband control block
`timescale 1ns/1ps
`include "pipe_lane_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module pipe_lane_control_inputs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic detect_loopback, compliance, rx_polarity, tx_swing, tx_deemph, powerup_done;
  logic com_skp_seen, ts_seen, eidle_exit, start_detect, start_loopback, detect_active;
  logic loopback_active, force_neg_disparity, rx_invert, half_swing, deemph_3p5db;
  logic eidle_inferred;
  logic [1:0] powerdown, rate, power_state;
  logic [2:0] tx_margin, rx_preset_hint, eidle_infer_sel, margin, rx_preset;
  logic [17:0] gen3_tx_coefficients, c;
  logic [5:0] coef_pre, coef_main, coef_post;
  int bad_count, checks, seed, em;
  int codes[$] = '{0, 1, 4, 5, 6, 7};
  int dtab[5][4] = '{'{0, 0, 1, 1}, '{0, 1, 0, 0}, '{0, 1, 1, 1}, '{1, 1, 1, 0},
    '{1, 0, 0, 1}};
  int itab[6][3] = '{'{5, 0, 20}, '{6, 0, 32}, '{7, 0, 50}, '{4, 0, 50}, '{5, 1, 10},
    '{6, 1, 128}};

  pipe_lane_control #(
    .LONG_WINDOW(50)
  ) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .detect_loopback(detect_loopback), .compliance(compliance), .rx_polarity(rx_polarity),
    .powerdown(powerdown), .tx_margin(tx_margin), .tx_swing(tx_swing), .tx_deemph(tx_deemph),
    .gen3_tx_coefficients(gen3_tx_coefficients), .rx_preset_hint(rx_preset_hint),
    .eidle_infer_sel(eidle_infer_sel), .rate(rate), .powerup_done(powerup_done),
    .com_skp_seen(com_skp_seen), .ts_seen(ts_seen), .eidle_exit(eidle_exit),
    .start_detect(start_detect), .start_loopback(start_loopback),
    .detect_active(detect_active), .loopback_active(loopback_active),
    .force_neg_disparity(force_neg_disparity), .rx_invert(rx_invert),
    .power_state(power_state), .margin(margin), .half_swing(half_swing),
    .deemph_3p5db(deemph_3p5db), .coef_pre(coef_pre), .coef_main(coef_main),
    .coef_post(coef_post), .rx_preset(rx_preset), .eidle_inferred(eidle_inferred)
  );
  pipe_mac_model mac (
    .pclk(pclk), .detect_loopback(detect_loopback), .compliance(compliance),
    .rx_polarity(rx_polarity), .powerdown(powerdown), .tx_margin(tx_margin),
    .tx_swing(tx_swing), .tx_deemph(tx_deemph), .gen3_tx_coefficients(gen3_tx_coefficients),
    .rx_preset_hint(rx_preset_hint), .eidle_infer_sel(eidle_infer_sel), .rate(rate)
  );

  // Free-running 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : step

  // One APB transfer; read data and error taken at the completing edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task pulse_ev();
    @(posedge pclk);
    {com_skp_seen, ts_seen, eidle_exit} <= 3'h7;
    @(posedge pclk);
    {com_skp_seen, ts_seen, eidle_exit} <= 3'h0;
  endtask : pulse_ev

  task print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    {powerup_done, com_skp_seen, ts_seen, eidle_exit} = 4'h0;
    {bad_count, checks, seed} = {32'h0, 32'h0, 32'd56067};
    step(15);
    `CHK(power_state, 2'h2)
    @(posedge pclk) presetn <= 1'b1;
    apb(0, `CTRL_OFFSET, 0);
    `CHK(rd, 32'h1)
    apb(0, 12'h010, 0);
    `CHK({err, rd}, 33'h100000000)
    for (int p = 0; p < 4; p++)
    begin
      mac.set_power(2'(p));
      step(1);
      `CHK(power_state, p[1:0])
      apb(0, `STATUS_OFFSET, 0);
      `CHK(rd[1:0], p[1:0])
    end
    mac.set_detect(1);
    step(1);
    `CHK({start_detect, start_loopback, detect_active}, 3'b101)
    step(1);
    `CHK(start_detect, 1'b0)
    mac.set_detect(0);
    powerup_done <= 1'b1;
    step(1);
    mac.set_detect(1);
    step(1);
    `CHK({start_detect, start_loopback, loopback_active}, 3'b011)
    mac.pulse_comp();
    #1;
    `CHK(force_neg_disparity, 1'b1)
    step(1);
    `CHK(force_neg_disparity, 1'b0)
    foreach (codes[i])
    begin
      c = 18'($random(seed));
      mac.set_tx(3'(codes[i]), c[0], 0);
      step(1);
      `CHK({half_swing, margin}, {c[0], 3'(codes[i])})
      em = codes[i];
    end
    mac.set_tx(3'b010, 0, 1);
    step(1);
    `CHK(margin, 3'(em))
    apb(0, `STATUS_OFFSET, 0);
    `CHK(rd[8], 1'b1)
    mac.set_tx(0, 0, 0);
    apb(1, `STATUS_OFFSET, 32'h100);
    apb(0, `STATUS_OFFSET, 0);
    `CHK(rd[8], 1'b0)
    c = 18'($random(seed));
    mac.set_mode(2'h2, 3'h0);
    mac.set_async(1, c[0], c, c[2:0]);
    step(4);
    `CHK({rx_invert, rx_preset}, {1'b1, c[2:0]})
    `CHK({coef_post, coef_main, coef_pre}, {c[17:12], c[11:6], c[5:0]})
    apb(0, `COEF_OFFSET, 0);
    `CHK(rd[17:0], c)
    foreach (dtab[j])
    begin
      apb(1, `CTRL_OFFSET, {30'h0, dtab[j][0][0], 1'b1});
      mac.set_mode(2'(dtab[j][1]), 0);
      mac.set_async(1, dtab[j][2][0], c, c[2:0]);
      step(4);
      `CHK(deemph_3p5db, dtab[j][3][0])
    end
    apb(1, `CTRL_OFFSET, 32'h1);
    foreach (itab[i])
    begin
      mac.set_mode(2'(itab[i][1]), 3'(itab[i][0]));
      // Window restarts three cycles after the select changes
      step(itab[i][2] + 2);
      `CHK(eidle_inferred, 1'b0)
      step(1);
      `CHK(eidle_inferred, 1'b1)
      pulse_ev();
      step(2);
      `CHK(eidle_inferred, 1'b0)
    end
    mac.set_mode(0, 3'h3);
    step(60);
    `CHK(eidle_inferred, 1'b0)
    print_verdict();
  end

  // Watchdog against a hung run
  initial
  begin
    #(25 * 20000);
    bad_count++;
    print_verdict();
  end
endmodule : pipe_lane_control_inputs_tb
